// ### cmgr_pkg.sv
// shared constants and types for the clock manager control block
`default_nettype none
package cmgr_pkg;
   // register indices on the configuration port
   localparam logic [2:0] CMGR_IDX_PHASE = 3'h4;
   localparam logic [2:0] CMGR_IDX_MODE = 3'h5;
   localparam logic [2:0] CMGR_IDX_OSEL = 3'h6;
   localparam logic [2:0] CMGR_IDX_CTRL = 3'h7;
   // implemented bits per register, reserved bits read zero
   localparam logic [7:0] CMGR_PHASE_MASK = 8'h1F;
   localparam logic [7:0] CMGR_MODE_MASK = 8'h15;
   localparam logic [7:0] CMGR_OSEL_MASK = 8'hF0;
   localparam logic [7:0] CMGR_CTRL_MASK = 8'hC7;
   localparam logic [7:0] CMGR_REG_RESET = 8'h00;
   // field positions
   localparam int CMGR_MODE_PLL = 0;
   localparam int CMGR_MODE_2X = 4;
   localparam int CMGR_OSEL_IO_LO = 4;
   localparam int CMGR_OSEL_SYS_LO = 6;
   localparam int CMGR_CTRL_PWR = 0;
   localparam int CMGR_CTRL_ALL_RST = 1;
   localparam int CMGR_CTRL_DLL_RST = 2;
   localparam int CMGR_CTRL_CFG_RUN = 6;
   localparam int CMGR_CTRL_GSR_IMM = 7;
   localparam int CMGR_PHASE_W = 5;
   // phase in quarter degrees: 11.25 deg is 45 quarters, 360 deg is 1440
   localparam logic signed [11:0] CMGR_QDEG_STEP = 12'sh02D;
   localparam logic signed [11:0] CMGR_QDEG_WRAP = 12'sh5A0;
   localparam logic [4:0] CMGR_PHASE_SPLIT = 5'h10;
   // output source codes
   typedef enum logic [1:0] {
      CMGR_SRC_BYPASS = 2'h0,
      CMGR_SRC_DLL = 2'h1,
      CMGR_SRC_TAP = 2'h2,
      CMGR_SRC_DIV = 2'h3
   } cmgr_src_e;
   // lock tracker states, one-hot
   typedef enum logic [2:0] {
      CMGR_ST_OFF = 3'b001,
      CMGR_ST_ACQ = 3'b010,
      CMGR_ST_LOCK = 3'b100
   } cmgr_lock_e;
endpackage
`default_nettype wire

// ### cmgr_dly_if.sv
// bundle between the control logic and the delay line
`timescale 1ns/1ns
`default_nettype none
interface cmgr_dly_if #(parameter int TAP_W = 5);
   logic sample; // filtered reference clock level
   logic line_rst; // clears the delay taps
   logic div_rst; // clears the half-rate divider
   logic dbl_en; // enables the 2x output of the delay loop
   logic [TAP_W-1:0] tap_sel; // tap chosen for phase delay
   logic tap_out; // tapped delay line output
   logic dll_out; // delay-loop output
   logic div_out; // half-rate divided tap output
   modport ctrl (output sample, line_rst, div_rst, dbl_en, tap_sel, input tap_out, dll_out, div_out);
   modport line (input sample, line_rst, div_rst, dbl_en, tap_sel, output tap_out, dll_out, div_out);
endinterface
`default_nettype wire

// ### cmgr_delay_line.sv
// tapped delay line, delay-loop output and half-rate divider
`timescale 1ns/1ns
`default_nettype none
module cmgr_delay_line
   import cmgr_pkg::*;
#(
   parameter int TAPS = 32 // taps spanning one reference period
) (
   input wire logic mclk, // system clock
   input wire logic sys_rst, // async reset, active high
   cmgr_dly_if.line dl // delay line bundle
);
   logic [TAPS-1:0] line_reg; // delay taps, tap 0 newest
   logic [TAPS-1:0] line_next;
   logic tap_prev_reg; // last tap level, for edge detect
   logic div_reg; // half-rate divider flop
   logic div_next;
   logic dll_reg; // registered delay-loop output
   logic tap_reg; // registered tap output
   wire tap_w = line_reg[dl.tap_sel]; // selected tap
   wire tap_rise_w = tap_w & ~tap_prev_reg; // tap rising edge
   // full-period tap re-aligns with the input; quarter tap makes the 2x edge
   wire dll_w = dl.dbl_en ? (line_reg[TAPS-1] ^ line_reg[TAPS/4-1]) : line_reg[TAPS-1];

   // R10 delay only
   assign line_next = dl.line_rst ? '0 : {line_reg[TAPS-2:0], dl.sample};
   // R12 half-rate divider
   // divider keeps its count through a delay-loop reset
   assign div_next = dl.div_rst ? 1'b0 : (tap_rise_w ? ~div_reg : div_reg);

   // shift the sampled reference along the taps
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         line_reg <= '0;
         tap_prev_reg <= 1'b0;
         div_reg <= 1'b0;
         dll_reg <= 1'b0;
         tap_reg <= 1'b0;
      end else begin
         line_reg <= line_next;
         tap_prev_reg <= tap_w;
         div_reg <= div_next;
         dll_reg <= dl.line_rst ? 1'b0 : dll_w;
         tap_reg <= tap_w;
      end
   end

   assign dl.tap_out = tap_reg;
   assign dl.dll_out = dll_reg;
   assign dl.div_out = div_reg;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // tap zero gives exactly one cycle of delay, never an advance
   a_tap_only_delay: assert property ((dl.tap_sel == '0 && !dl.line_rst) |=> line_reg[0] == $past(dl.sample)) // R10
      else $error("tap zero not one sample behind");
   // divider toggles only on a tap rising edge
   a_div_on_edge: assert property ((!dl.div_rst && !tap_rise_w) |=> $stable(div_reg)) // R12
      else $error("divider moved without tap edge");
endmodule
`default_nettype wire

// ### cmgr_ctrl.sv
// clock manager control registers, resets, lock tracking and output selection
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// R1: io clock source bypass, loop, tap, divided
// R2: system clock source bypass, loop, tap
// R3: control bit 0 switches analog supply
// R4: control bit 1 resets whole manager
// R5: control bit 2 resets delay loop only
// R6: bit6 low, config pending: off, tristate, unlocked
// R7: bit6 high lets manager run during configuration
// R8: bit7 high makes manager immune to global reset
// R9: phase is delay times 11.25, wraps at 16 and above
// R10: phase adjusted only by delaying the clock
// R11: two outputs, divider only on io path
// R12: system clock runs divider times io rate
// R13: configurer keeps multiplication within rate limits
// R14: avoid divider with duty-adjusted clocks
// R15: mode bit 0 delay-locked, 1 phase-locked
// R16: 2x select in delay-locked mode only
module cmgr_ctrl
   import cmgr_pkg::*;
#(
   parameter int TAPS = 32, // delay taps per reference period
   parameter int LOCK_CYCLES = 64 // cycles from release to lock
) (
   input wire logic mclk, // 100 MHz system clock
   input wire logic sys_rst, // async reset, active high
   input wire logic ref_clk_pin, // reference clock pin
   input wire logic global_set_reset_n, // chip-wide reset, active low
   input wire logic cfg_done, // configuration done pin
   input wire logic cfg_wr_en, // register write strobe
   input wire logic cfg_rd_en, // register read strobe
   input wire logic [2:0] cfg_addr, // register index
   input wire logic [7:0] cfg_wdata, // write data
   output logic [7:0] cfg_rdata, // read data bus
   output logic cfg_rdata_oe_n, // read bus enable, low drives
   output logic io_clk_out, // fast io clock output
   output logic sys_clk_out, // system clock output
   output logic analog_pwr_on, // analog supply switch
   output logic lock, // lock flag
   output logic signed [11:0] phase_qdeg // phase in quarter degrees
);
   localparam int LCW = $clog2(LOCK_CYCLES + 1); // lock counter width
   localparam logic [LCW-1:0] LOCK_LAST = LCW'(LOCK_CYCLES - 1);
   // pins at rest: global reset released, so no false chip reset follows sys_rst
   localparam logic [2:0] SYNC_IDLE = 3'h2;

   // three-stage pin synchronisers: ref, global reset, config done
   logic [2:0] sync1_reg; // first stage, read only by second
   logic [2:0] sync2_reg; // second stage
   logic [2:0] sync3_reg; // third stage
   logic [2:0] filt_reg; // accepted levels
   logic [2:0] filt_next;

   // configuration registers
   logic [7:0] phase_reg; // own phase tap register
   logic [7:0] mode_reg; // mode register
   logic [7:0] osel_reg; // output source register
   logic [7:0] ctrl_reg; // control register
   logic [7:0] rdata_reg; // read data flop
   logic [7:0] rdata_next;
   logic rd_oe_reg; // read data enable flop

   // lock tracker
   cmgr_lock_e lock_st_reg; // lock state
   cmgr_lock_e lock_st_next;
   logic [LCW-1:0] lock_cnt_reg; // acquisition counter
   logic [LCW-1:0] lock_cnt_next;

   // output flops
   logic io_clk_reg; // io clock flop
   logic sys_clk_reg; // system clock flop
   logic signed [11:0] phase_q_reg; // phase readout flop
   logic signed [11:0] phase_q_next;

   cmgr_dly_if #(.TAP_W(CMGR_PHASE_W)) dly (); // delay line bundle

   // pick the clock for a source code; reserved code falls back to bypass
   function automatic logic cmgr_pick(input logic [1:0] src, input logic allow_div,
                                      input logic byp, input logic dll, input logic tap, input logic div);
      logic r;
      r = byp;
      case (src)
         CMGR_SRC_BYPASS: r = byp;
         CMGR_SRC_DLL: r = dll;
         CMGR_SRC_TAP: r = tap;
         CMGR_SRC_DIV: r = allow_div ? div : byp;
         default: r = byp;
      endcase
      return r;
   endfunction

   // accept a level only once stages two and three agree
   assign filt_next = (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg | sync3_reg));

   // synchroniser chain
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_reg <= SYNC_IDLE;
         sync2_reg <= SYNC_IDLE;
         sync3_reg <= SYNC_IDLE;
         filt_reg <= SYNC_IDLE;
      end else begin
         sync1_reg <= {cfg_done, global_set_reset_n, ref_clk_pin};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         filt_reg <= filt_next;
      end
   end

   // named views of the accepted pin levels
   wire ref_w = filt_reg[0]; // reference clock
   wire gsr_n_w = filt_reg[1]; // global reset, low active
   wire done_w = filt_reg[2]; // configuration done

   // configuration register fields
   // R15 mode select bit
   wire pll_mode_w = mode_reg[CMGR_MODE_PLL]; // 1 phase-locked
   wire sel_2x_w = mode_reg[CMGR_MODE_2X]; // 2x request
   wire [1:0] io_src_w = osel_reg[CMGR_OSEL_IO_LO +: 2]; // io clock source
   wire [1:0] sys_src_w = osel_reg[CMGR_OSEL_SYS_LO +: 2]; // system clock source
   wire cfg_run_w = ctrl_reg[CMGR_CTRL_CFG_RUN]; // run during configuration
   wire gsr_imm_w = ctrl_reg[CMGR_CTRL_GSR_IMM]; // ignore global reset
   wire [CMGR_PHASE_W-1:0] tap_w = phase_reg[CMGR_PHASE_W-1:0]; // delay setting

   // R7 configuration gate
   wire cfg_ok_w = cfg_run_w | done_w;
   // R3 supply switch
   wire pwr_w = ctrl_reg[CMGR_CTRL_PWR] & cfg_ok_w;
   // R8 global reset reach
   wire gsr_hit_w = ~gsr_n_w & ~gsr_imm_w;
   // R4 whole manager reset
   wire mgr_rst_w = ctrl_reg[CMGR_CTRL_ALL_RST] | gsr_hit_w;
   // R5 delay loop only reset, also held while unpowered
   wire dll_rst_w = mgr_rst_w | ctrl_reg[CMGR_CTRL_DLL_RST] | ~pwr_w;

   // register write decode
   wire wr_phase_w = cfg_wr_en & (cfg_addr == CMGR_IDX_PHASE);
   wire wr_mode_w = cfg_wr_en & (cfg_addr == CMGR_IDX_MODE);
   wire wr_osel_w = cfg_wr_en & (cfg_addr == CMGR_IDX_OSEL);
   wire wr_ctrl_w = cfg_wr_en & (cfg_addr == CMGR_IDX_CTRL);

   // configuration registers keep their values through manager resets
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_reg <= CMGR_REG_RESET;
         mode_reg <= CMGR_REG_RESET;
         osel_reg <= CMGR_REG_RESET;
         ctrl_reg <= CMGR_REG_RESET;
      end else begin
         if (wr_phase_w) phase_reg <= cfg_wdata & CMGR_PHASE_MASK;
         if (wr_mode_w) mode_reg <= cfg_wdata & CMGR_MODE_MASK;
         if (wr_osel_w) osel_reg <= cfg_wdata & CMGR_OSEL_MASK;
         if (wr_ctrl_w) ctrl_reg <= cfg_wdata & CMGR_CTRL_MASK;
      end
   end

   // read mux; unmapped indices read zero
   always_comb begin
      rdata_next = 8'h00;
      case (cfg_addr)
         CMGR_IDX_PHASE: rdata_next = phase_reg;
         CMGR_IDX_MODE: rdata_next = mode_reg;
         CMGR_IDX_OSEL: rdata_next = osel_reg;
         CMGR_IDX_CTRL: rdata_next = ctrl_reg;
         default: rdata_next = 8'h00;
      endcase
   end

   // read data flop; bus floats while configuration holds the manager off
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_reg <= 8'h00;
         rd_oe_reg <= 1'b0;
      end else begin
         rdata_reg <= cfg_rd_en ? rdata_next : rdata_reg;
         rd_oe_reg <= cfg_rd_en;
      end
   end

   // R6 tri-state bus
   assign cfg_rdata_oe_n = ~(rd_oe_reg & cfg_ok_w);
   assign cfg_rdata = rdata_reg;

   // feed the delay line
   assign dly.sample = ref_w;
   assign dly.line_rst = dll_rst_w;
   // R5 dividers survive loop reset
   assign dly.div_rst = mgr_rst_w;
   // R16 2x in delay-locked only
   assign dly.dbl_en = sel_2x_w & ~pll_mode_w;
   assign dly.tap_sel = tap_w;

   cmgr_delay_line #(.TAPS(TAPS)) u_line (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .dl(dly.line)
   );

   // lock tracker: count clean cycles after the loop is released
   always_comb begin
      lock_st_next = lock_st_reg;
      lock_cnt_next = lock_cnt_reg;
      case (lock_st_reg)
         CMGR_ST_OFF: begin
            lock_cnt_next = '0;
            if (!dll_rst_w) lock_st_next = CMGR_ST_ACQ;
         end
         CMGR_ST_ACQ: begin
            lock_cnt_next = lock_cnt_reg + LCW'(1);
            if (lock_cnt_reg == LOCK_LAST) lock_st_next = CMGR_ST_LOCK;
         end
         CMGR_ST_LOCK: lock_cnt_next = lock_cnt_reg;
         default: lock_st_next = CMGR_ST_OFF;
      endcase
      // any loop reset or power loss drops lock at once
      if (dll_rst_w) begin
         lock_st_next = CMGR_ST_OFF;
         lock_cnt_next = '0;
      end
   end

   // lock state flops
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         lock_st_reg <= CMGR_ST_OFF;
         lock_cnt_reg <= '0;
      end else begin
         lock_st_reg <= lock_st_next;
         lock_cnt_reg <= lock_cnt_next;
      end
   end

   // R9 phase readout, setting 16 taken with the wrapped half
   assign phase_q_next = (tap_w < CMGR_PHASE_SPLIT) ?
      12'(CMGR_QDEG_STEP * $signed({7'h00, tap_w})) :
      12'(CMGR_QDEG_STEP * $signed({7'h00, tap_w}) - CMGR_QDEG_WRAP);

   // R1 io source, R11 divider only here
   wire io_pick_w = cmgr_pick(io_src_w, 1'b1, ref_w, dly.dll_out, dly.tap_out, dly.div_out);
   // R2 system source, reserved code bypasses
   wire sys_pick_w = cmgr_pick(sys_src_w, 1'b0, ref_w, dly.dll_out, dly.tap_out, dly.div_out);

   // output flops; a manager reset parks both clocks low
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         io_clk_reg <= 1'b0;
         sys_clk_reg <= 1'b0;
         phase_q_reg <= 12'sh000;
      end else begin
         io_clk_reg <= mgr_rst_w ? 1'b0 : io_pick_w;
         sys_clk_reg <= mgr_rst_w ? 1'b0 : sys_pick_w;
         phase_q_reg <= phase_q_next;
      end
   end

   assign io_clk_out = io_clk_reg;
   assign sys_clk_out = sys_clk_reg;
   assign analog_pwr_on = pwr_w;
   // R6 lock forced low
   assign lock = (lock_st_reg == CMGR_ST_LOCK) & cfg_ok_w;
   assign phase_qdeg = phase_q_reg;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   a_io_bypass_sel: assert property ((!mgr_rst_w && io_src_w == CMGR_SRC_BYPASS) |=> io_clk_out == $past(ref_w)) // R1
      else $error("io clock not following bypass");
   a_io_div_sel: assert property ((!mgr_rst_w && io_src_w == CMGR_SRC_DIV) |=> io_clk_out == $past(dly.div_out)) // R1
      else $error("io clock not following divider");
   a_sys_rsvd_sel: assert property ((!mgr_rst_w && sys_src_w == CMGR_SRC_DIV) |=> sys_clk_out == $past(ref_w)) // R2
      else $error("system clock reserved code not bypass");
   a_pwr_follows_bit: assert property (wr_ctrl_w |=> // R3
      analog_pwr_on == ($past(cfg_wdata[CMGR_CTRL_PWR]) && (cfg_run_w || done_w)))
      else $error("supply not following control bit");
   a_all_rst_hold: assert property (ctrl_reg[CMGR_CTRL_ALL_RST] |=> !io_clk_out && !sys_clk_out && !lock) // R4
      else $error("outputs alive under manager reset");
   a_dll_rst_keeps: assert property ((ctrl_reg[CMGR_CTRL_DLL_RST] && !mgr_rst_w) |=> $stable(osel_reg) or $past(wr_osel_w)) // R5
      else $error("registers disturbed by loop reset");
   a_cfg_hold_off: assert property ((!cfg_run_w && !done_w) |-> !analog_pwr_on && !lock && cfg_rdata_oe_n) // R6
      else $error("manager active during configuration");
   a_cfg_run_pwr: assert property ((cfg_run_w && ctrl_reg[CMGR_CTRL_PWR]) |-> analog_pwr_on) // R7
      else $error("supply off with run-in-config set");
   a_gsr_immune: assert property ((gsr_imm_w && !ctrl_reg[CMGR_CTRL_ALL_RST] && lock && !ctrl_reg[CMGR_CTRL_DLL_RST]
      && pwr_w) |=> lock || !$stable(ctrl_reg) || !pwr_w) // R8
      else $error("global reset disturbed immune manager");
   a_phase_wrap: assert property ($past(tap_w) == 5'h11 && $stable(tap_w) |-> phase_qdeg == -12'sd675) // R9
      else $error("phase wrap value wrong");
   a_lock_timing: assert property ($rose(lock_st_reg == CMGR_ST_ACQ) |-> (lock_st_reg != CMGR_ST_LOCK)[*8]
      or LOCK_CYCLES < 9) // R5
      else $error("lock acquisition cut short");
   a_pll_no_2x: assert property (pll_mode_w |-> !dly.dbl_en) // R16
      else $error("2x active in phase-locked mode");

   c_io_divided: cover property (io_src_w == CMGR_SRC_DIV && sys_src_w == CMGR_SRC_TAP && $rose(io_clk_out));
   c_locked: cover property ($rose(lock));
   c_gsr_ignored: cover property (gsr_imm_w && !gsr_n_w && lock);
endmodule
`default_nettype wire

// ### cmgr_ctrl_bench.sv
// self-checking bench for the clock manager control block
`timescale 1ns/1ns
`default_nettype none
module cmgr_ctrl_bench
   import cmgr_pkg::*;
;
   localparam int LOCKN = 10; // shortened lock count
   logic mclk; // system clock
   logic sys_rst; // async reset
   logic ref_clk_pin; // reference clock
   logic global_set_reset_n; // chip reset, low active
   logic cfg_done; // configuration done
   logic cfg_wr_en; // write strobe
   logic cfg_rd_en; // read strobe
   logic [2:0] cfg_addr; // register index
   logic [7:0] cfg_wdata; // write data
   logic [7:0] cfg_rdata; // read data
   logic cfg_rdata_oe_n; // read bus enable
   logic io_clk_out; // io clock
   logic sys_clk_out; // system clock out
   logic analog_pwr_on; // supply switch
   logic lock; // lock flag
   logic signed [11:0] phase_qdeg; // phase
   int mismatches; // failed compares
   int check_count; // compares made

   cmgr_ctrl #(.TAPS(32), .LOCK_CYCLES(LOCKN)) dut (
      .mclk(mclk), .sys_rst(sys_rst), .ref_clk_pin(ref_clk_pin),
      .global_set_reset_n(global_set_reset_n), .cfg_done(cfg_done),
      .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rdata_oe_n(cfg_rdata_oe_n),
      .io_clk_out(io_clk_out), .sys_clk_out(sys_clk_out),
      .analog_pwr_on(analog_pwr_on), .lock(lock), .phase_qdeg(phase_qdeg));

   // clock source, 10 ns period
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // reference rate kept inside the usable range
   // reference period equals 32 mclk cycles, so the loop can align
   initial begin
      ref_clk_pin = 1'b0;
      #10;
      forever #160 ref_clk_pin = ~ref_clk_pin;
   end

   // value compare, four-state exact
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // edge count compare, with slack for phase of the window
   task automatic chk_rng(input string what, input int lo, input int hi, input int got);
      check_count++;
      if (got < lo || got > hi) begin
         mismatches++;
         $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask

   // one register write, strobe held across one rising edge
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge mclk);
      cfg_wr_en = 1'b1;
      cfg_addr = a;
      cfg_wdata = d;
      @(negedge mclk);
      cfg_wr_en = 1'b0;
   endtask

   // one register read; data and enable sampled in the answer cycle
   task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic oe_n);
      @(negedge mclk);
      cfg_rd_en = 1'b1;
      cfg_addr = a;
      @(negedge mclk);
      cfg_rd_en = 1'b0;
      d = cfg_rdata;
      oe_n = cfg_rdata_oe_n;
   endtask

   // bounded wait for the lock flag to reach a level
   task automatic wait_lock(input logic exp, input int max);
      int n;
      n = 0;
      while (lock !== exp && n < max) begin
         @(negedge mclk);
         n++;
      end
      chk("lock", {11'h000, exp}, {11'h000, lock});
   endtask

   // counts rising edges of both clock outputs over a window
   task automatic count_rises(input int n, output int ci, output int cs);
      logic pi;
      logic ps;
      ci = 0;
      cs = 0;
      pi = io_clk_out;
      ps = sys_clk_out;
      repeat (n) begin
         @(negedge mclk);
         if (io_clk_out === 1'b1 && pi !== 1'b1) ci++;
         if (sys_clk_out === 1'b1 && ps !== 1'b1) cs++;
         pi = io_clk_out;
         ps = sys_clk_out;
      end
   endtask

   // configuration pending: supply off, bus quiet, unlocked
   task automatic t_cfg_gate;
      logic [7:0] d;
      logic oe;
      rd(CMGR_IDX_CTRL, d, oe);
      chk("ctrl reset", 12'(CMGR_REG_RESET), 12'(d));
      chk("oe_n pending", 12'h001, 12'(oe));
      wr(CMGR_IDX_CTRL, 8'h01);
      repeat (200) @(negedge mclk);
      chk("pwr pending", 12'h000, 12'(analog_pwr_on));
      chk("lock pending", 12'h000, 12'(lock));
      cfg_done = 1'b1;
      repeat (8) @(negedge mclk);
      chk("pwr done", 12'h001, 12'(analog_pwr_on));
      rd(CMGR_IDX_CTRL, d, oe);
      chk("ctrl read", 12'h001, 12'(d));
      chk("oe_n done", 12'h000, 12'(oe));
      wait_lock(1'b1, 400);
      wr(CMGR_IDX_CTRL, 8'h00);
      chk("pwr off", 12'h000, 12'(analog_pwr_on));
   endtask

   // run-during-configuration bit opens the gate
   task automatic t_cfg_run;
      logic [7:0] d;
      logic oe;
      cfg_done = 1'b0;
      wr(CMGR_IDX_CTRL, 8'h41);
      repeat (8) @(negedge mclk);
      chk("pwr run", 12'h001, 12'(analog_pwr_on));
      rd(CMGR_IDX_CTRL, d, oe);
      chk("oe_n run", 12'h000, 12'(oe));
      wait_lock(1'b1, 400);
      wr(CMGR_IDX_CTRL, 8'h01);
      wait_lock(1'b0, 8);
      cfg_done = 1'b1;
      repeat (8) @(negedge mclk);
   endtask

   // implemented bits and an unmapped index
   task automatic t_masks;
      logic [7:0] d;
      logic oe;
      logic [2:0] idx [4] = '{3'h2, CMGR_IDX_PHASE, CMGR_IDX_MODE, CMGR_IDX_OSEL};
      logic [7:0] msk [4] = '{8'h00, CMGR_PHASE_MASK, CMGR_MODE_MASK, CMGR_OSEL_MASK};
      for (int i = 0; i < 4; i++) begin
         rd(idx[i], d, oe);
         chk("reg reset", 12'h000, 12'(d));
         wr(idx[i], 8'hFF);
         rd(idx[i], d, oe);
         chk("reg mask", 12'(msk[i]), 12'(d));
         wr(idx[i], 8'h00);
      end
      wr(CMGR_IDX_CTRL, 8'hFF);
      rd(CMGR_IDX_CTRL, d, oe);
      chk("ctrl mask", 12'(CMGR_CTRL_MASK), 12'(d));
      wr(CMGR_IDX_CTRL, 8'h01);
   endtask

   // loop reset, manager reset and the global reset with immunity
   task automatic t_resets;
      int ci;
      int cs;
      wait_lock(1'b1, 400);
      wr(CMGR_IDX_CTRL, 8'h05);
      wait_lock(1'b0, 4);
      wr(CMGR_IDX_CTRL, 8'h01);
      wait_lock(1'b1, 400);
      wr(CMGR_IDX_CTRL, 8'h03);
      repeat (3) @(negedge mclk);
      count_rises(64, ci, cs);
      chk_rng("io parked", 0, 0, ci);
      chk_rng("sys parked", 0, 0, cs);
      chk("lock mgr rst", 12'h000, 12'(lock));
      wr(CMGR_IDX_CTRL, 8'h01);
      wait_lock(1'b1, 400);
      global_set_reset_n = 1'b0;
      wait_lock(1'b0, 8);
      global_set_reset_n = 1'b1;
      wait_lock(1'b1, 400);
      wr(CMGR_IDX_CTRL, 8'h81);
      global_set_reset_n = 1'b0;
      repeat (40) @(negedge mclk);
      chk("lock immune", 12'h001, 12'(lock));
      global_set_reset_n = 1'b1;
      wr(CMGR_IDX_CTRL, 8'h01);
   endtask

   // every output source, 2x select and mode bit; ten reference periods
   task automatic t_sources;
      int ci;
      int cs;
      // divider used only with unadjusted duty cycle
      logic [7:0] osel [6] = '{8'h00, 8'h50, 8'hA0, 8'hF0, 8'h10, 8'h10};
      logic [7:0] mode [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h11};
      int eio [6] = '{10, 10, 10, 5, 20, 10};
      for (int i = 0; i < 6; i++) begin
         wr(CMGR_IDX_OSEL, osel[i]);
         wr(CMGR_IDX_MODE, mode[i]);
         wait_lock(1'b1, 400);
         repeat (40) @(negedge mclk);
         count_rises(320, ci, cs);
         chk_rng("io rises", eio[i] - 1, eio[i] + 1, ci);
         chk_rng("sys rises", 9, 11, cs);
      end
      wr(CMGR_IDX_MODE, 8'h00);
   endtask

   // phase per delay setting, wrapping at and above sixteen
   task automatic t_phase;
      logic [4:0] s [6] = '{5'h00, 5'h01, 5'h0F, 5'h10, 5'h11, 5'h1F};
      int e;
      for (int i = 0; i < 6; i++) begin
         wr(CMGR_IDX_PHASE, {3'h0, s[i]});
         repeat (3) @(negedge mclk);
         e = (s[i] < 16) ? int'(s[i]) * 45 : int'(s[i]) * 45 - 1440;
         chk("phase", 12'(e), phase_qdeg);
      end
   endtask

   // closing report and verdict
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // hang guard, well beyond the expected run length
   initial begin
      #200_000;
      mismatches++;
      summarize();
   end

   // main sequence
   initial begin
      mismatches = 0;
      check_count = 0;
      sys_rst = 1'b1;
      global_set_reset_n = 1'b1;
      cfg_done = 1'b0;
      cfg_wr_en = 1'b0;
      cfg_rd_en = 1'b0;
      cfg_addr = 3'h0;
      cfg_wdata = 8'h00;
      repeat (5) @(negedge mclk);
      chk("pwr in reset", 12'h000, 12'(analog_pwr_on));
      sys_rst = 1'b0;
      t_cfg_gate();
      t_cfg_run();
      t_masks();
      t_resets();
      t_sources();
      t_phase();
      summarize();
   end
endmodule
`default_nettype wire
